/* File: hw/process_scheduler_stack_core.sv */
// What this block does
// - Six registers: workspace, instruction pointer, status, three stack entries.
// - Push moves second to third, top to second, then loads top.
// - Pop moves second to top, third to second; third left as is.
// - Stack overflow beyond three entries is never detected or flagged.
// - Add takes top two entries and leaves the sum on top.
// - Multiply takes three cycles; shifts finish in one cycle.
// - Memory addresses formed as offsets from the workspace pointer.
// - Two linked active lists, one per priority, with front and back.
// - Inactive processes use no time; high priority runs until it blocks.
// - Low priority runs at least two timeslices, then goes to list tail.
// - Timeslice period is one millisecond.
// - Timeslicing happens only at timeslice points; stack contents are not checked.
// - Blocked process saves its instruction pointer; front of list dispatched.
// - Start-process appends the given workspace to the list tail.
// - Activated processes join the tail and never pre-empt their own list.
// - End-process decrements join counter; nonzero ends, zero resumes parent.
// - One pre-emption level, high over low, with a trap side per priority.
// - High process starts when idle or low runs and high list non-empty.
// - Pre-empted low state goes to shadow, restored at next switch with high list empty.
`timescale 1ns/100ps
module process_scheduler_stack_core
  import sched_pkg::*;
#(
  parameter int NPROC = 16,
  parameter int TICKS = TIMESLICE_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [WORD_W-1:0] cmd_data,
  input wire logic cmd_pri,
  output logic cmd_ready,
  output logic [WORD_W-1:0] top_entry,
  output logic [WORD_W-1:0] second_entry,
  output logic [WORD_W-1:0] third_entry,
  output logic [WORD_W-1:0] workspace_pointer,
  output logic [WORD_W-1:0] instruction_pointer,
  output logic [STATUS_W-1:0] core_status_register,
  output logic [WORD_W-1:0] mem_addr,
  output logic [WORD_W-1:0] high_list_front,
  output logic [WORD_W-1:0] high_list_back,
  output logic [WORD_W-1:0] low_list_front,
  output logic [WORD_W-1:0] low_list_back,
  output logic trap_priority
);
  localparam int IDX_W = $clog2(NPROC);
  localparam logic [WORD_W-1:0] TICK_LAST = WORD_W'(TICKS - 1);
  localparam logic [WORD_W-1:0] TICK_STEP = 32'h00000001;

  typedef struct packed {
    state_e st;
    logic pri;
    logic ready;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic [WORD_W-1:0] c;
    logic [WORD_W-1:0] wptr;
    logic [WORD_W-1:0] iptr;
    logic [WORD_W-1:0] addr;
    logic [1:0][WORD_W-1:0] front;
    logic [1:0][WORD_W-1:0] back;
    logic sh_valid;
    logic [WORD_W-1:0] sh_wptr;
    logic [WORD_W-1:0] sh_iptr;
    logic [WORD_W-1:0] sh_a;
    logic [WORD_W-1:0] sh_b;
    logic [WORD_W-1:0] sh_c;
    logic [WORD_W-1:0] join_count;
    logic [WORD_W-1:0] join_parent;
    logic [WORD_W-1:0] tick;
    logic [1:0] slices;
    logic [STATUS_W-1:0] status;
  } core_s;

  core_s r;
  core_s next_r;
  logic [WORD_W-1:0] link_mem [NPROC];
  logic [WORD_W-1:0] ip_mem [NPROC];
  logic link_we;
  logic [IDX_W-1:0] link_idx;
  logic [WORD_W-1:0] link_data;
  logic ip_we;
  logic [IDX_W-1:0] ip_idx;
  logic [WORD_W-1:0] ip_data;
  logic app_en;
  logic app_pri;
  logic [WORD_W-1:0] app_w;
  logic take_en;
  logic take_pri;
  logic [WORD_W-1:0] take_w;
  logic accept;
  logic mul_start;
  logic mul_done;
  logic [WORD_W-1:0] mul_product;

  function automatic logic [IDX_W-1:0] slot(input logic [WORD_W-1:0] w);
    slot = w[WORD_SHIFT +: IDX_W];
  endfunction : slot

  assign accept = cmd_valid && r.ready;
  assign mul_start = accept && r.st == ST_RUN && cmd_op == OP_MUL;

  mul_unit mul (
    .clock(clock),
    .nrst(nrst),
    .start(mul_start),
    .left(r.b),
    .right(r.a),
    .done(mul_done),
    .product(mul_product)
  );

  always_comb begin
    next_r = r;
    link_we = 1'b0;
    link_idx = '0;
    link_data = WORD_ZERO;
    ip_we = 1'b0;
    ip_idx = '0;
    ip_data = WORD_ZERO;
    app_en = 1'b0;
    app_pri = cmd_pri;
    app_w = cmd_data;
    take_en = 1'b0;
    take_pri = PRI_HIGH;
    take_w = NOT_PROCESS;
    case (r.st)
      ST_IDLE, ST_SWITCH: begin
        if (r.st == ST_IDLE && accept) begin
          app_en = cmd_op == OP_STARTP;
        end else if (r.front[PRI_HIGH] != NOT_PROCESS) begin
          take_en = 1'b1;
          take_pri = PRI_HIGH;
        end else if (r.sh_valid) begin
          next_r.st = ST_RUN;
          next_r.pri = PRI_LOW;
          next_r.sh_valid = 1'b0;
          next_r.wptr = r.sh_wptr;
          next_r.iptr = r.sh_iptr;
          next_r.a = r.sh_a;
          next_r.b = r.sh_b;
          next_r.c = r.sh_c;
        end else if (r.front[PRI_LOW] != NOT_PROCESS) begin
          take_en = 1'b1;
          take_pri = PRI_LOW;
        end else begin
          next_r.st = ST_IDLE;
        end
      end
      ST_MUL: begin
        if (mul_done) begin
          next_r.st = ST_RUN;
          next_r.a = mul_product;
          next_r.b = r.c;
        end
      end
      default: begin
        if (r.pri == PRI_LOW && r.front[PRI_HIGH] != NOT_PROCESS) begin
          next_r.st = ST_SWITCH;
          next_r.sh_valid = 1'b1;
          next_r.sh_wptr = r.wptr;
          next_r.sh_iptr = r.iptr;
          next_r.sh_a = r.a;
          next_r.sh_b = r.b;
          next_r.sh_c = r.c;
        end else if (accept) begin
          case (cmd_op)
            OP_PUSH: begin
              next_r.c = r.b;
              next_r.b = r.a;
              next_r.a = cmd_data;
            end
            OP_POP: begin
              next_r.a = r.b;
              next_r.b = r.c;
            end
            OP_ADD: begin
              next_r.a = r.b + r.a;
              next_r.b = r.c;
            end
            OP_MUL: next_r.st = ST_MUL;
            OP_SHL: begin
              next_r.a = r.b << r.a[SHIFT_W-1:0];
              next_r.b = r.c;
            end
            OP_SHR: begin
              next_r.a = r.b >> r.a[SHIFT_W-1:0];
              next_r.b = r.c;
            end
            OP_WSADDR: next_r.addr = r.wptr + (cmd_data << WORD_SHIFT);
            OP_JUMP: next_r.iptr = cmd_data;
            OP_STARTP: begin
              app_en = 1'b1;
              ip_we = 1'b1;
              ip_idx = slot(cmd_data);
              ip_data = r.a;
            end
            OP_SETJOIN: begin
              next_r.join_count = cmd_data;
              next_r.join_parent = r.wptr;
            end
            OP_ENDP: begin
              next_r.join_count = r.join_count - JOIN_STEP;
              if (r.join_count == JOIN_STEP) begin
                next_r.wptr = r.join_parent;
                next_r.iptr = cmd_data;
              end else begin
                next_r.st = ST_SWITCH;
              end
            end
            OP_STOPP: begin
              next_r.st = ST_SWITCH;
              ip_we = 1'b1;
              ip_idx = slot(r.wptr);
              ip_data = r.iptr;
            end
            OP_TSLICE: begin
              if (r.pri == PRI_LOW && r.slices == SLICE_LIMIT) begin
                next_r.st = ST_SWITCH;
                ip_we = 1'b1;
                ip_idx = slot(r.wptr);
                ip_data = r.iptr;
                app_en = 1'b1;
                app_pri = PRI_LOW;
                app_w = r.wptr;
              end
            end
            default: next_r.st = ST_RUN;
          endcase
        end
      end
    endcase
    if (take_en) begin
      take_w = r.front[take_pri];
      next_r.st = ST_RUN;
      next_r.pri = take_pri;
      next_r.wptr = take_w;
      next_r.iptr = ip_mem[slot(take_w)];
      next_r.tick = WORD_ZERO;
      next_r.slices = 2'h0;
      if (take_w == r.back[take_pri]) begin
        next_r.front[take_pri] = NOT_PROCESS;
        next_r.back[take_pri] = NOT_PROCESS;
      end else begin
        next_r.front[take_pri] = link_mem[slot(take_w)];
      end
    end
    if (app_en) begin
      next_r.back[app_pri] = app_w;
      if (r.front[app_pri] == NOT_PROCESS) begin
        next_r.front[app_pri] = app_w;
      end else begin
        link_we = 1'b1;
        link_idx = slot(r.back[app_pri]);
        link_data = app_w;
      end
    end
    if (!take_en && r.pri == PRI_LOW && (r.st == ST_RUN || r.st == ST_MUL)) begin
      if (r.tick == TICK_LAST) begin
        next_r.tick = WORD_ZERO;
        if (r.slices != SLICE_LIMIT) begin
          next_r.slices = r.slices + SLICE_STEP;
        end
      end else begin
        next_r.tick = r.tick + TICK_STEP;
      end
    end
    next_r.ready = next_r.st == ST_IDLE || (next_r.st == ST_RUN
      && !(next_r.pri == PRI_LOW && next_r.front[PRI_HIGH] != NOT_PROCESS));
    next_r.status = '0;
    next_r.status[STAT_RUN_BIT] = next_r.st != ST_IDLE;
    next_r.status[STAT_PRI_BIT] = next_r.pri;
    next_r.status[STAT_SHADOW_BIT] = next_r.sh_valid;
    next_r.status[STAT_SLICE_BIT] = next_r.slices == SLICE_LIMIT;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
      r.front <= {NOT_PROCESS, NOT_PROCESS};
      r.back <= {NOT_PROCESS, NOT_PROCESS};
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clock) begin
    if (link_we) begin
      link_mem[link_idx] <= link_data;
    end
    if (ip_we) begin
      ip_mem[ip_idx] <= ip_data;
    end
  end

  assign cmd_ready = r.ready;
  assign top_entry = r.a;
  assign second_entry = r.b;
  assign third_entry = r.c;
  assign workspace_pointer = r.wptr;
  assign instruction_pointer = r.iptr;
  assign core_status_register = r.status;
  assign mem_addr = r.addr;
  assign high_list_front = r.front[PRI_HIGH];
  assign high_list_back = r.back[PRI_HIGH];
  assign low_list_front = r.front[PRI_LOW];
  assign low_list_back = r.back[PRI_LOW];
  assign trap_priority = r.pri;

  push_order_a: assert property (@(posedge clock) disable iff (!nrst)
    accept && r.st == ST_RUN && cmd_op == OP_PUSH |=>
    r.a == $past(cmd_data) && r.b == $past(r.a) && r.c == $past(r.b))
    else $error("push did not shift stack");
  pop_order_a: assert property (@(posedge clock) disable iff (!nrst)
    accept && r.st == ST_RUN && cmd_op == OP_POP |=>
    r.a == $past(r.b) && r.b == $past(r.c))
    else $error("pop did not shift stack");
  add_result_a: assert property (@(posedge clock) disable iff (!nrst)
    accept && r.st == ST_RUN && cmd_op == OP_ADD |=> r.a == $past(r.a) + $past(r.b))
    else $error("add result wrong");
  mul_latency_a: assert property (@(posedge clock) disable iff (!nrst)
    mul_start |=> (r.st == ST_MUL)[*3] ##1
    (r.st == ST_RUN && r.a == WORD_W'($past(r.a, 4) * $past(r.b, 4))))
    else $error("multiply not done in three cycles");
  shift_result_a: assert property (@(posedge clock) disable iff (!nrst)
    accept && r.st == ST_RUN && cmd_op == OP_SHL |=>
    r.a == $past(r.b) << $past(r.a[SHIFT_W-1:0]))
    else $error("shift not single cycle");
  ws_offset_a: assert property (@(posedge clock) disable iff (!nrst)
    accept && r.st == ST_RUN && cmd_op == OP_WSADDR |=>
    r.addr == $past(r.wptr) + ($past(cmd_data) << WORD_SHIFT))
    else $error("workspace address wrong");
  high_preempt_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == ST_RUN && r.pri == PRI_LOW && r.front[PRI_HIGH] != NOT_PROCESS |=>
    r.st == ST_SWITCH && r.sh_valid ##1 r.st == ST_RUN && r.pri == PRI_HIGH)
    else $error("high process did not pre-empt");
  slice_tail_a: assert property (@(posedge clock) disable iff (!nrst)
    accept && r.st == ST_RUN && cmd_op == OP_TSLICE && r.pri == PRI_LOW
    && r.slices == SLICE_LIMIT && r.front[PRI_HIGH] == NOT_PROCESS |=>
    r.st == ST_SWITCH && r.back[PRI_LOW] == $past(r.wptr))
    else $error("timeslice did not append to tail");
  high_holds_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == ST_RUN && r.pri == PRI_HIGH && !accept |=> r.wptr == $past(r.wptr))
    else $error("high process lost the core");
endmodule : process_scheduler_stack_core

/* File: hw/sched_pkg.sv */
package sched_pkg;
  localparam int WORD_W = 32;
  localparam int WORD_SHIFT = 2;
  localparam int SHIFT_W = 5;
  localparam logic [31:0] NOT_PROCESS = 32'h80000000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [31:0] JOIN_STEP = 32'h00000001;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMESLICE_NS = 1000000;
  localparam int TIMESLICE_CYCLES = TIMESLICE_NS / CLK_PERIOD_NS;
  localparam int MUL_CYCLES = 3;
  localparam logic [1:0] SLICE_LIMIT = 2'h2;
  localparam logic [1:0] SLICE_STEP = 2'h1;
  localparam logic PRI_HIGH = 1'b0;
  localparam logic PRI_LOW = 1'b1;
  localparam int STATUS_W = 4;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_PRI_BIT = 1;
  localparam int STAT_SHADOW_BIT = 2;
  localparam int STAT_SLICE_BIT = 3;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_PUSH = 4'h1,
    OP_POP = 4'h2,
    OP_ADD = 4'h3,
    OP_MUL = 4'h4,
    OP_SHL = 4'h5,
    OP_SHR = 4'h6,
    OP_WSADDR = 4'h7,
    OP_JUMP = 4'h8,
    OP_STARTP = 4'h9,
    OP_ENDP = 4'hA,
    OP_STOPP = 4'hB,
    OP_TSLICE = 4'hC,
    OP_SETJOIN = 4'hD
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_MUL = 2'b11,
    ST_SWITCH = 2'b10
  } state_e;
endpackage : sched_pkg

/* File: hw/mul_unit.sv */
`timescale 1ns/100ps
module mul_unit
  import sched_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [WORD_W-1:0] left,
  input wire logic [WORD_W-1:0] right,
  output logic done,
  output logic [WORD_W-1:0] product
);
  typedef struct packed {
    logic [1:0] count;
    logic busy;
    logic done;
    logic [WORD_W-1:0] left;
    logic [WORD_W-1:0] right;
    logic [WORD_W-1:0] product;
  } mul_s;

  localparam logic [1:0] LOAD_COUNT = 2'(MUL_CYCLES - 1);
  localparam logic [1:0] LAST_COUNT = 2'h1;

  mul_s r;
  mul_s next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.busy = 1'b1;
      next_r.count = LOAD_COUNT;
      next_r.left = left;
      next_r.right = right;
    end else if (r.busy) begin
      next_r.count = r.count - LAST_COUNT;
      if (r.count == LAST_COUNT) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.product = WORD_W'(r.left * r.right);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign product = r.product;
endmodule : mul_unit

/* File: verif/process_scheduler_stack_core_tb.sv */
`timescale 1ns/100ps
module process_scheduler_stack_core_tb
  import sched_pkg::*;
;
  localparam int TICKS_SIM = 20;
  localparam logic [31:0] W1 = 32'h00000104;
  localparam logic [31:0] W2 = 32'h00000208;
  localparam logic [31:0] W3 = 32'h0000030C;
  logic clock;
  logic nrst;
  logic cmd_valid;
  logic [3:0] cmd_op;
  logic [WORD_W-1:0] cmd_data;
  logic cmd_pri;
  logic cmd_ready;
  logic [WORD_W-1:0] top_entry;
  logic [WORD_W-1:0] second_entry;
  logic [WORD_W-1:0] third_entry;
  logic [WORD_W-1:0] workspace_pointer;
  logic [WORD_W-1:0] instruction_pointer;
  logic [STATUS_W-1:0] core_status_register;
  logic [WORD_W-1:0] mem_addr;
  logic [WORD_W-1:0] high_list_front;
  logic [WORD_W-1:0] high_list_back;
  logic [WORD_W-1:0] low_list_front;
  logic [WORD_W-1:0] low_list_back;
  logic trap_priority;
  int n_mismatch;
  int total_checks;
  int cycles;
  int n;
  logic [STATUS_W-1:0] status_before;

  process_scheduler_stack_core #(.NPROC(16), .TICKS(TICKS_SIM)) i_dut (
    .clock(clock),
    .nrst(nrst),
    .cmd_valid(cmd_valid),
    .cmd_op(cmd_op),
    .cmd_data(cmd_data),
    .cmd_pri(cmd_pri),
    .cmd_ready(cmd_ready),
    .top_entry(top_entry),
    .second_entry(second_entry),
    .third_entry(third_entry),
    .workspace_pointer(workspace_pointer),
    .instruction_pointer(instruction_pointer),
    .core_status_register(core_status_register),
    .mem_addr(mem_addr),
    .high_list_front(high_list_front),
    .high_list_back(high_list_back),
    .low_list_front(low_list_front),
    .low_list_back(low_list_back),
    .trap_priority(trap_priority)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    total_checks++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask : check

  // Holds the request until cmd_ready is sampled high, then drops it
  task automatic do_cmd(input op_e op, input logic [31:0] data, input logic pri);
    int k;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = data;
    cmd_pri = pri;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (cmd_ready !== 1'b1 && k < 200);
    if (k >= 200) begin
      check(1'b0, 1'b1);
    end
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : do_cmd

  // Waits at falling edges until the core accepts again
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (cmd_ready !== 1'b1 && cnt < 200) begin
      @(negedge clock);
      cnt++;
    end
    if (cnt >= 200) begin
      check(1'b0, 1'b1);
    end
  endtask : wait_ready

  always @(posedge clock) begin
    cycles++;
    if (cycles >= 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_data = 32'h00000000;
    cmd_pri = 1'b0;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    check(high_list_front, NOT_PROCESS);
    check(low_list_back, NOT_PROCESS);
    check(core_status_register, 32'h00000000);
    do_cmd(OP_PUSH, 32'h00000055, 1'b0);
    check(top_entry, 32'h00000000);
    do_cmd(OP_STARTP, W1, PRI_LOW);
    check(low_list_front, W1);
    check(low_list_back, W1);
    @(negedge clock);
    check(workspace_pointer, W1);
    check(core_status_register[STAT_RUN_BIT], 1'b1);
    check(trap_priority, PRI_LOW);
    do_cmd(OP_PUSH, 32'h00000001, 1'b0);
    do_cmd(OP_PUSH, 32'h00000002, 1'b0);
    do_cmd(OP_PUSH, 32'h00000003, 1'b0);
    check({top_entry[7:0], second_entry[7:0], third_entry[7:0]}, 32'h00030201);
    status_before = core_status_register;
    do_cmd(OP_PUSH, 32'h00000004, 1'b0);
    check({top_entry[7:0], second_entry[7:0], third_entry[7:0]}, 32'h00040302);
    check(core_status_register, status_before);
    do_cmd(OP_POP, 32'h00000000, 1'b0);
    check({top_entry[7:0], second_entry[7:0]}, 32'h00000302);
    do_cmd(OP_ADD, 32'h00000000, 1'b0);
    check(top_entry, 32'h00000005);
    do_cmd(OP_PUSH, 32'h00000007, 1'b0);
    do_cmd(OP_MUL, 32'h00000000, 1'b0);
    wait_ready(n);
    check(n, 32'h00000003);
    check(top_entry, 32'h00000023);
    do_cmd(OP_PUSH, 32'h00000004, 1'b0);
    do_cmd(OP_SHL, 32'h00000000, 1'b0);
    check(top_entry, 32'h00000230);
    check(second_entry, 32'h00000002);
    do_cmd(OP_PUSH, 32'h00000004, 1'b0);
    do_cmd(OP_SHR, 32'h00000000, 1'b0);
    check(top_entry, 32'h00000023);
    do_cmd(OP_JUMP, 32'h00000040, 1'b0);
    check(instruction_pointer, 32'h00000040);
    do_cmd(OP_WSADDR, 32'h00000003, 1'b0);
    check(mem_addr, W1 + 32'h0000000C);
    do_cmd(OP_STARTP, W2, PRI_HIGH);
    check(high_list_back, W2);
    wait_ready(n);
    check(workspace_pointer, W2);
    check(trap_priority, PRI_HIGH);
    check(core_status_register[STAT_SHADOW_BIT], 1'b1);
    check(high_list_back, NOT_PROCESS);
    do_cmd(OP_STOPP, 32'h00000000, 1'b0);
    wait_ready(n);
    @(negedge clock);
    check(workspace_pointer, W1);
    check(trap_priority, PRI_LOW);
    check(core_status_register[STAT_SHADOW_BIT], 1'b0);
    check(high_list_front, NOT_PROCESS);
    do_cmd(OP_STARTP, W3, PRI_LOW);
    @(negedge clock);
    check(low_list_back, W3);
    check(workspace_pointer, W1);
    repeat (3 * TICKS_SIM) @(negedge clock);
    check(core_status_register[STAT_SLICE_BIT], 1'b1);
    do_cmd(OP_TSLICE, 32'h00000000, 1'b0);
    check(low_list_back, W1);
    wait_ready(n);
    @(negedge clock);
    check(workspace_pointer, W3);
    do_cmd(OP_TSLICE, 32'h00000000, 1'b0);
    repeat (2) @(negedge clock);
    check(workspace_pointer, W3);
    do_cmd(OP_SETJOIN, 32'h00000002, 1'b0);
    do_cmd(OP_ENDP, 32'h00000ABC, 1'b0);
    wait_ready(n);
    @(negedge clock);
    check(workspace_pointer, W1);
    do_cmd(OP_ENDP, 32'h00000ABC, 1'b0);
    wait_ready(n);
    @(negedge clock);
    check(workspace_pointer, W3);
    check(instruction_pointer, 32'h00000ABC);
    stop_test();
  end
endmodule : process_scheduler_stack_core_tb
